// [design/mbsp_pkg.sv]
// Shared constants and types for the baseband serial data port
package mbsp_pkg;
    // Core clock rate in MHz, and link timing in core clock cycles
    localparam int CLK_MHZ              = 250;
    localparam int RX_ENABLE_LOW_MCLK   = 4;
    localparam int RX_DROP_DELAY_MCLK   = 3;
    localparam int TX_TAIL_MCLK         = 8;
    localparam logic [3:0] RX_ENABLE_LOW_CYCLES = 4'(RX_ENABLE_LOW_MCLK);
    localparam logic [3:0] RX_DROP_CYCLES       = 4'(RX_DROP_DELAY_MCLK);
    localparam logic [3:0] TX_TAIL_CYCLES       = 4'(TX_TAIL_MCLK);

    // Synchroniser lane positions
    localparam int SY_TXCLK = 0;
    localparam int SY_TXRDY = 1;
    localparam int SY_RXCLK = 2;
    localparam int SY_MDV   = 3;
    localparam int SY_RXBIT = 4;
    localparam int SY_LANES = 5;

    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_RUN  = 3'b010,
        TX_TAIL = 3'b100
    } mbsp_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_RUN  = 3'b010,
        RX_DROP = 3'b100
    } mbsp_rx_state_t;
endpackage

// [design/mbsp_rx_link_if.sv]
// Carrier between the receive-clock capture stage and the core
`timescale 1ns/1ns
interface mbsp_rx_link_if;
    logic capturedBit;
    modport link (output capturedBit);
    modport core (input capturedBit);
endinterface

// [design/mbsp_rx_capture.sv]
// Receive data capture flop on the receive bit clock
`timescale 1ns/1ns
module mbsp_rx_capture
    import mbsp_pkg::*;
(
    // Link side
    input  wire logic        receiveBitClock,
    input  wire logic        rst_b,
    input  wire logic        receiveSerialData,
    // Core side
    mbsp_rx_link_if.link     link
);
    // Bit is held stable for a whole bit period, so the core can resample it
    always_ff @(posedge receiveBitClock or negedge rst_b) begin
        if (!rst_b) begin
            link.capturedBit <= 1'b0;
        end else begin
            link.capturedBit <= receiveSerialData;
        end
    end
endmodule

// [design/mbsp_serial_port.sv]
// Bit-serial transmit and receive data port towards the baseband processor
// What this block does
// - Shift transmit bit on ready and pulse
// - No transmit shifting after final bit driven
// - Drop transmit enable cycles after last bit
// - Take receive bit on valid and pulse
// - Stop receiving after header length bit count
// - Capture receive data on receive clock edge
// - Receive enable stays low four core clocks
// - Early valid drop lets timers clear enable
`timescale 1ns/1ns
module mbsp_serial_port
    import mbsp_pkg::*;
(
    // Core clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Transmit pins
    input  wire logic        transmitBitClock,
    input  wire logic        transmitReady,
    output logic             transmitSerialData,
    output logic             transmitPathEnable,
    // Receive pins
    input  wire logic        receiveBitClock,
    input  wire logic        receiveSerialData,
    input  wire logic        modemDataValid,
    output logic             receivePathEnable,
    // Transmit user side
    input  wire logic        txStart,
    input  wire logic        txByteValid,
    input  wire logic [7:0]  txByte,
    input  wire logic        txByteLast,
    output logic             txByteReady,
    output logic             txBusy,
    // Receive user side
    input  wire logic        rxStart,
    input  wire logic [15:0] rxBitCount,
    output logic             rxReady,
    output logic [7:0]       rxByte,
    output logic             rxByteValid,
    output logic             rxDone,
    output logic             rxAborted
);
    typedef struct packed {
        logic [SY_LANES-1:0] syncA;
        logic [SY_LANES-1:0] syncB;
        logic [1:0]          txClkDly;
        logic [1:0]          rxClkDly;
        mbsp_tx_state_t      txState;
        logic [7:0]          txShift;
        logic [3:0]          txBits;
        logic                txLast;
        logic                txData;
        logic                txEnable;
        logic [3:0]          txCount;
        mbsp_rx_state_t      rxState;
        logic [7:0]          rxShift;
        logic [2:0]          rxBitIdx;
        logic [15:0]         rxRemain;
        logic [3:0]          rxCount;
        logic                rxEnable;
        logic                rxValidSeen;
        logic [7:0]          rxByte;
        logic                rxByteValid;
        logic                rxDone;
        logic                rxAborted;
    } mbsp_state_t;

    mbsp_state_t cur;
    mbsp_state_t next_cur;
    mbsp_rx_link_if rxLink ();

    logic txPulse;
    logic rxPulse;
    logic txReadySync;
    logic mdvSync;
    logic txShiftNow;
    logic rxTakeNow;
    logic rxValidDrop;

    mbsp_rx_capture u_capture (
        .receiveBitClock   (receiveBitClock),
        .rst_b             (rst_b),
        .receiveSerialData (receiveSerialData),
        .link              (rxLink.link)
    );

    // Rising edge seen one stage after the synchroniser
    function automatic logic rise(input logic [1:0] dly);
        rise = dly[0] & ~dly[1];
    endfunction

    // Pulses come one stage late so the resynchronised data bit has settled
    assign txPulse     = rise(cur.txClkDly);
    assign rxPulse     = rise(cur.rxClkDly);
    assign txReadySync = cur.syncB[SY_TXRDY];
    assign mdvSync     = cur.syncB[SY_MDV];
    assign txShiftNow  = (cur.txState == TX_RUN) && txPulse && txReadySync;
    assign rxTakeNow   = (cur.rxState == RX_RUN) && rxPulse && mdvSync;
    // Valid rises only once the baseband has the header, so only a fall aborts
    assign rxValidDrop = (cur.rxState == RX_RUN) && cur.rxValidSeen && !mdvSync;

    always_comb begin
        next_cur = cur;
        next_cur.syncA = {rxLink.capturedBit, modemDataValid, receiveBitClock,
                          transmitReady, transmitBitClock};
        next_cur.syncB = cur.syncA;
        next_cur.txClkDly = {cur.txClkDly[0], cur.syncB[SY_TXCLK]};
        next_cur.rxClkDly = {cur.rxClkDly[0], cur.syncB[SY_RXCLK]};
        next_cur.rxByteValid = 1'b0;
        next_cur.rxDone = 1'b0;
        next_cur.rxAborted = 1'b0;

        unique case (cur.txState)
            TX_IDLE: begin
                if (txStart) begin
                    next_cur.txState = TX_RUN;
                    next_cur.txEnable = 1'b1;
                    next_cur.txBits = 4'h0;
                    next_cur.txLast = 1'b0;
                end
            end
            TX_RUN: begin
                // First bit of each byte is put on the wire before its clock edge
                if (cur.txBits == 4'h0 && !cur.txLast && txByteValid) begin
                    next_cur.txData = txByte[0];
                    next_cur.txShift = {1'b0, txByte[7:1]};
                    next_cur.txBits = BYTE_BITS;
                    next_cur.txLast = txByteLast;
                end else if (txShiftNow && cur.txBits != 4'h0) begin
                    next_cur.txBits = cur.txBits - 4'h1;
                    if (cur.txBits != 4'h1) begin
                        next_cur.txData = cur.txShift[0];
                        next_cur.txShift = {1'b0, cur.txShift[7:1]};
                    end else if (cur.txLast) begin
                        next_cur.txState = TX_TAIL;
                        next_cur.txCount = TX_TAIL_CYCLES;
                    end else begin
                        next_cur.txBits = 4'h0;
                    end
                end
            end
            TX_TAIL: begin
                // Ready stays high from the baseband until the enable drops
                if (cur.txCount == 4'h1) begin
                    next_cur.txEnable = 1'b0;
                    next_cur.txState = TX_IDLE;
                    next_cur.txCount = 4'h0;
                end else begin
                    next_cur.txCount = cur.txCount - 4'h1;
                end
            end
        endcase

        unique case (cur.rxState)
            RX_IDLE: begin
                if (cur.rxCount != 4'h0) begin
                    next_cur.rxCount = cur.rxCount - 4'h1;
                end else if (rxStart && rxBitCount != 16'h0) begin
                    next_cur.rxState = RX_RUN;
                    next_cur.rxEnable = 1'b1;
                    next_cur.rxRemain = rxBitCount;
                    next_cur.rxBitIdx = 3'h0;
                    next_cur.rxValidSeen = 1'b0;
                end
            end
            RX_RUN: begin
                if (mdvSync) begin
                    next_cur.rxValidSeen = 1'b1;
                end
                if (rxTakeNow) begin
                    next_cur.rxShift = {cur.syncB[SY_RXBIT], cur.rxShift[7:1]};
                    next_cur.rxBitIdx = cur.rxBitIdx + 3'h1;
                    next_cur.rxRemain = cur.rxRemain - 16'h1;
                    // A short final byte is right aligned by the shift below
                    if (cur.rxBitIdx == 3'h7 || cur.rxRemain == 16'h1) begin
                        next_cur.rxByte = {cur.syncB[SY_RXBIT], cur.rxShift[7:1]}
                                          >> (3'h7 - cur.rxBitIdx);
                        next_cur.rxByteValid = 1'b1;
                    end
                    if (cur.rxRemain == 16'h1) begin
                        next_cur.rxState = RX_IDLE;
                        next_cur.rxEnable = 1'b0;
                        next_cur.rxDone = 1'b1;
                        next_cur.rxCount = RX_ENABLE_LOW_CYCLES - 4'h1;
                    end
                end else if (rxValidDrop) begin
                    next_cur.rxState = RX_DROP;
                    next_cur.rxCount = RX_DROP_CYCLES - 4'h1;
                end
            end
            RX_DROP: begin
                if (cur.rxCount == 4'h0) begin
                    next_cur.rxState = RX_IDLE;
                    next_cur.rxEnable = 1'b0;
                    next_cur.rxAborted = 1'b1;
                    next_cur.rxCount = RX_ENABLE_LOW_CYCLES - 4'h1;
                end else begin
                    next_cur.rxCount = cur.rxCount - 4'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= '{txState: TX_IDLE, rxState: RX_IDLE, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign transmitSerialData = cur.txData;
    assign transmitPathEnable = cur.txEnable;
    assign receivePathEnable  = cur.rxEnable;
    assign txByteReady = (cur.txState == TX_RUN) && cur.txBits == 4'h0 && !cur.txLast;
    assign txBusy      = cur.txState != TX_IDLE;
    assign rxReady     = (cur.rxState == RX_IDLE) && cur.rxCount == 4'h0;
    assign rxByte      = cur.rxByte;
    assign rxByteValid = cur.rxByteValid;
    assign rxDone      = cur.rxDone;
    assign rxAborted   = cur.rxAborted;

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence txLastBitTaken_s;
        txShiftNow && cur.txBits == 4'h1 && cur.txLast;
    endsequence
    sequence rxFrameEnds_s;
        $fell(receivePathEnable);
    endsequence

    tx_shift_gate_a: assert property (
        $changed(cur.txShift) && $past(cur.txBits) != 4'h0
        |-> $past(txPulse && txReadySync))
        else $error("transmit shift without ready and pulse");
    tx_no_shift_after_a: assert property (
        cur.txState == TX_TAIL |-> $stable(transmitSerialData) && $stable(cur.txShift))
        else $error("transmit data moved after final bit");
    tx_enable_drop_a: assert property (
        txLastBitTaken_s |=> transmitPathEnable [*8] ##1 !transmitPathEnable)
        else $error("transmit enable not dropped after tail");
    rx_take_gate_a: assert property (
        cur.rxRemain != $past(cur.rxRemain) && $past(cur.rxState) == RX_RUN
        |-> $past(rxPulse && mdvSync))
        else $error("receive bit taken without valid and pulse");
    rx_count_stop_a: assert property (
        rxTakeNow && cur.rxRemain == 16'h1 |=> rxDone && !receivePathEnable)
        else $error("receive did not stop at bit count");
    rx_enable_low_a: assert property (
        rxFrameEnds_s |-> !receivePathEnable [*4])
        else $error("receive enable low time too short");
    rx_drop_clear_a: assert property (
        rxValidDrop
        |-> ##[1:4] (rxAborted && !receivePathEnable))
        else $error("receive enable not cleared after valid drop");
    sync_pulse_a: assert property (
        rxPulse |-> $past(cur.syncB[SY_RXCLK]) && !$past(cur.syncB[SY_RXCLK], 2))
        else $error("receive pulse not from synchronised edge");
endmodule

// [test/mbsp_bb_model.sv]
// Behavioural baseband partner for the serial data port
`timescale 1ns/1ns
module mbsp_bb_model (
    // From the port
    input  wire logic transmitSerialData,
    input  wire logic transmitPathEnable,
    input  wire logic receivePathEnable,
    // To the port
    output logic      transmitBitClock,
    output logic      transmitReady,
    output logic      receiveBitClock,
    output logic      receiveSerialData,
    output logic      modemDataValid
);
    logic    capBit[$];
    realtime capTime[$];
    realtime fallTime;

    initial begin
        transmitBitClock  = 1'b0;
        transmitReady     = 1'b0;
        receiveBitClock   = 1'b0;
        receiveSerialData = 1'b0;
        modemDataValid    = 1'b0;
    end

    // Clock runs only while enabled; the first edges stand for the preamble time
    always @(posedge transmitPathEnable) begin : txLink
        int k;
        #5;
        for (k = 0; k < 400 && transmitPathEnable === 1'b1; k++) begin
            if (k == 3) transmitReady = 1'b1;
            #16 transmitBitClock = 1'b1;
            if (transmitReady) begin
                capBit.push_back(transmitSerialData);
                capTime.push_back($realtime);
            end
            #16 transmitBitClock = 1'b0;
        end
        transmitReady = 1'b0;
    end

    always @(negedge transmitPathEnable) fallTime = $realtime;

    // Bits past the frame are junk, so a port that overreads shows wrong data
    task automatic runRx(input logic [15:0] pat, input int dropAt);
        int i;
        modemDataValid = 1'b1;
        for (i = 0; i < 40 && receivePathEnable === 1'b1; i++) begin
            if (i == dropAt) modemDataValid = 1'b0;
            receiveSerialData = (i < 16) ? pat[i] : ~receiveSerialData;
            #8 receiveBitClock = 1'b1;
            #16 receiveBitClock = 1'b0;
            #8;
        end
        modemDataValid    = 1'b0;
        receiveSerialData = ~receiveSerialData;
    endtask
endmodule

// [test/mbsp_serial_port_bench.sv]
// Self-checking bench for the baseband serial data port
`timescale 1ns/1ns
module mbsp_serial_port_bench;
    logic        clk, rst_b, txStart, txByteValid, txByteLast, rxStart;
    logic [7:0]  txByte, rxByte;
    logic [15:0] rxBitCount;
    logic        transmitBitClock, transmitReady, receiveBitClock;
    logic        receiveSerialData, modemDataValid;
    logic        transmitSerialData, transmitPathEnable, receivePathEnable;
    logic        txByteReady, txBusy, rxReady, rxByteValid, rxDone, rxAborted;
    int          n_errors, total_checks;

    always #2 clk = ~clk;

    mbsp_serial_port u_dut (.clk(clk), .rst_b(rst_b),
        .transmitBitClock(transmitBitClock), .transmitReady(transmitReady),
        .transmitSerialData(transmitSerialData), .transmitPathEnable(transmitPathEnable),
        .receiveBitClock(receiveBitClock), .receiveSerialData(receiveSerialData),
        .modemDataValid(modemDataValid), .receivePathEnable(receivePathEnable),
        .txStart(txStart), .txByteValid(txByteValid), .txByte(txByte),
        .txByteLast(txByteLast), .txByteReady(txByteReady), .txBusy(txBusy),
        .rxStart(rxStart), .rxBitCount(rxBitCount), .rxReady(rxReady), .rxByte(rxByte),
        .rxByteValid(rxByteValid), .rxDone(rxDone), .rxAborted(rxAborted));

    mbsp_bb_model u_bb (.transmitSerialData(transmitSerialData),
        .transmitPathEnable(transmitPathEnable), .receivePathEnable(receivePathEnable),
        .transmitBitClock(transmitBitClock), .transmitReady(transmitReady),
        .receiveBitClock(receiveBitClock), .receiveSerialData(receiveSerialData),
        .modemDataValid(modemDataValid));

    task tick;
        @(posedge clk);
        #1;
    endtask

    task summarize;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task guard(input int n, input int lim);
        if (n >= lim) begin
            n_errors++;
            $display("BAD t=%0t wait=%h limit=%h", $time, n, lim);
            summarize;
        end
    endtask

    // Two-byte frame; the second byte ends in a one so a stray shift shows
    task txCase;
        logic [15:0] frame;
        int          i, n;
        realtime     gap;
        frame = 16'hc3a5;
        txStart = 1'b1;
        tick;
        txStart = 1'b0;
        check(transmitPathEnable, 16'h1);
        for (i = 0; i < 2; i++) begin
            for (n = 0; n < 400 && txByteReady !== 1'b1; n++) tick;
            guard(n, 400);
            txByteValid = 1'b1;
            txByte      = frame[8*i +: 8];
            txByteLast  = (i == 1);
            tick;
            txByteValid = 1'b0;
        end
        for (n = 0; n < 2000 && txBusy !== 1'b0; n++) tick;
        guard(n, 2000);
        for (i = 0; i < 16; i++) check(u_bb.capBit[i], frame[i]);
        check(u_bb.capBit[16], frame[15]);
        gap = u_bb.fallTime - u_bb.capTime[15];
        check(gap >= 32.0 && gap < 100.0, 16'h1);
    endtask

    task rxCase(input logic [15:0] cnt, input logic [15:0] pat, input int dropAt);
        logic [7:0] got[$];
        logic       done, abrt;
        int         n, k, b;
        got.delete();
        for (n = 0; n < 100 && rxReady !== 1'b1; n++) tick;
        guard(n, 100);
        rxStart    = 1'b1;
        rxBitCount = cnt;
        tick;
        rxStart = 1'b0;
        check(receivePathEnable, 16'h1);
        done = 1'b0;
        abrt = 1'b0;
        fork
            u_bb.runRx(pat, dropAt);
            for (n = 0; n < 3000 && !done && !abrt; n++) begin
                tick;
                if (rxByteValid === 1'b1) got.push_back(rxByte);
                done = (rxDone === 1'b1);
                abrt = (rxAborted === 1'b1);
            end
        join_any
        guard(n, 3000);
        check(receivePathEnable, 16'h0);
        if (dropAt < cnt) begin
            check(abrt, 16'h1);
        end else begin
            check(done, 16'h1);
            check(got.size(), (cnt + 7) / 8);
            for (k = 0; k < (cnt + 7) / 8; k++) begin
                b = (cnt - 8 * k > 8) ? 8 : cnt - 8 * k;
                check(got[k], (pat >> (8 * k)) & ((16'h1 << b) - 1));
            end
        end
        // A start offered during the low hold must be refused
        rxStart = 1'b1;
        for (k = 0; k < 3; k++) begin
            tick;
            check(receivePathEnable, 16'h0);
        end
        rxStart = 1'b0;
        repeat (12) tick;
    endtask

    initial begin
        clk         = 1'b0;
        rst_b       = 1'b0;
        txStart     = 1'b0;
        txByteValid = 1'b0;
        txByteLast  = 1'b0;
        txByte      = 8'h00;
        rxStart     = 1'b0;
        rxBitCount  = 16'h0000;
        n_errors     = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        check(rxReady, 16'h1);
        check(txByteReady, 16'h0);
        txCase;
        rxCase(16'h0009, 16'h5bb5, 99);
        rxCase(16'h0010, 16'hc35a, 99);
        rxCase(16'h0010, 16'h1234, 5);
        summarize;
    end
endmodule
